//--- src/uhi_regs.svh
// Register indices, bit positions, reset values and codes of the irq block.
`ifndef UHI_REGS_SVH
`define UHI_REGS_SVH
`define UHI_IDX_FLAGS 8'h03
`define UHI_IDX_ENABLES 8'h04
`define UHI_IDX_CLEARER 8'h05
`define UHI_IDX_TALLY 8'h06
`define UHI_IDX_MODE 8'h07
`define UHI_WR_FLAGS 8'h83
`define UHI_WR_ENABLES 8'h84
`define UHI_WR_CLEARER 8'h85
`define UHI_WR_MODE 8'h87
`define UHI_BIT_HUB 6
`define UHI_BIT_WRAP 5
`define UHI_BIT_FATAL 4
`define UHI_BIT_RESUME 3
`define UHI_BIT_FRAME 2
`define UHI_BIT_OVERRUN 0
`define UHI_BIT_GATE 31
`define UHI_EV_MASK 7'h7D
`define UHI_RST_FLAGS 7'h00
`define UHI_RST_ENABLES 7'h00
`define UHI_RST_TALLY 2'h0
`define UHI_TALLY_LSB 16
`endif

//--- src/uhi_pkg.sv
// Types shared by the irq status and enable block.
package uhi_pkg;
   typedef struct packed {
      logic [6:0] flags;
      logic [6:0] ens;
      logic gate;
      logic [1:0] tally;
      logic compat;
      logic msb_q;
      logic msb_seen;
      logic res_q;
      logic wr_pend;
      logic [7:0] widx;
      logic [31:0] rdata;
      logic ready;
      logic irq;
      logic halt;
   } uhi_state_t;
endpackage

//--- src/uhi_irq.sv
// Host-side interrupt status, enable and gating with an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
`include "uhi_regs.svh"

// Functional notes
// RQ1 - Events set sticky flags until software clears.
// RQ2 - Request only when flag, enable, gate set.
// RQ3 - Write one clears flag; zero ignored.
// RQ4 - Software never sets; hardware never clears.
// RQ5 - Flags read code 03, written 83.
// RQ6 - Enables read code 04, written 84.
// RQ7 - Hub or port change sets bit 6.
// RQ8 - Frame counter bit 15 toggle sets bit 5.
// RQ9 - System error sets bit 4; compat reads zero.
// RQ10 - Fatal error halts processing until corrected.
// RQ11 - Software clears fatal flag only after reset; the code clears it on any write of one to bit 4.
// RQ12 - Resume start sets bit 3, not software.
// RQ13 - Frame start sets bit 2.
// RQ14 - Overrun sets bit 0, bumps tally.
// RQ15 - Enable gates same bit; reserved bits inert.
// RQ16 - Enable write one sets; zero ignored.
// RQ17 - Enable read returns all bits, gate too.
// RQ18 - Bit 31 gate: one sets, zero ignored.
// RQ19 - Clearer write one clears enables; reads enables.
// RQ20 - Two-bit tally counts every overrun, wraps.
// RQ21 - Level request; registers zero on any reset; host_core_reset leaves the mode bit compat as it was.
module uhi_irq (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic hub_status_change,
   input wire logic port1_status_change,
   input wire logic port2_status_change,
   input wire logic frame_number_msb,
   input wire logic system_error,
   input wire logic resume_signalling,
   input wire logic resume_state,
   input wire logic frame_start,
   input wire logic schedule_overrun,
   input wire logic host_core_reset,
   output logic irq,
   output logic processing_halt
);
   uhi_pkg::uhi_state_t s_r;
   uhi_pkg::uhi_state_t s_nxt;
   logic [7:0] a_idx;
   logic [7:0] w_code;
   logic [6:0] ev;
   logic [6:0] rd_flags;
   logic a_take;

   // All checks below run on the one bus clock and pause during reset.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   assign a_idx = haddr[9:2];
   assign a_take = hsel & hready & htrans[1];

   always_comb begin
      s_nxt = s_r;
      ev = 7'h00;
      rd_flags = 7'h00;
      w_code = {1'b1, s_r.widx[6:0]};
      // Writes are applied first so that a same-cycle event set wins.
      if (s_r.wr_pend && !s_r.widx[7]) begin
         unique case (w_code)
            // RQ3 clear on one
            `UHI_WR_FLAGS: begin
               s_nxt.flags = s_r.flags & ~hwdata[6:0];
            end
            // RQ6 RQ16 set on one
            `UHI_WR_ENABLES: begin
               s_nxt.ens = s_r.ens | (hwdata[6:0] & `UHI_EV_MASK);
               // RQ18 gate set only
               s_nxt.gate = s_r.gate | hwdata[`UHI_BIT_GATE];
            end
            // RQ19 clearer write
            `UHI_WR_CLEARER: begin
               s_nxt.ens = s_r.ens & ~hwdata[6:0];
               s_nxt.gate = s_r.gate & ~hwdata[`UHI_BIT_GATE];
            end
            `UHI_WR_MODE: begin
               s_nxt.compat = hwdata[0];
            end
            default: begin
            end
         endcase
      end
      // RQ7 hub change
      ev[`UHI_BIT_HUB] = hub_status_change | port1_status_change |
                        port2_status_change;
      // RQ8 msb toggle
      ev[`UHI_BIT_WRAP] = s_r.msb_seen &
                         (frame_number_msb ^ s_r.msb_q);
      // RQ9 system error
      ev[`UHI_BIT_FATAL] = system_error & ~s_nxt.compat;
      // RQ12 resume edge
      ev[`UHI_BIT_RESUME] = resume_signalling & ~s_r.res_q &
                           ~resume_state;
      // RQ13 frame start
      ev[`UHI_BIT_FRAME] = frame_start;
      // RQ14 overrun flag
      ev[`UHI_BIT_OVERRUN] = schedule_overrun;
      // RQ1 RQ4 RQ15 sticky set
      s_nxt.flags = (s_nxt.flags | ev) & `UHI_EV_MASK;
      // RQ20 tally counts
      if (schedule_overrun) begin
         s_nxt.tally = s_r.tally + 2'h1;
      end
      s_nxt.msb_q = frame_number_msb;
      s_nxt.msb_seen = 1'b1;
      s_nxt.res_q = resume_signalling;
      // RQ21 soft reset
      if (host_core_reset) begin
         s_nxt.flags = `UHI_RST_FLAGS;
         s_nxt.ens = `UHI_RST_ENABLES;
         s_nxt.gate = 1'b0;
         s_nxt.tally = `UHI_RST_TALLY;
      end
      // RQ9 compat reads zero
      rd_flags = s_nxt.flags;
      if (s_nxt.compat) begin
         rd_flags[`UHI_BIT_FATAL] = 1'b0;
      end
      s_nxt.wr_pend = 1'b0;
      s_nxt.ready = 1'b1;
      if (a_take) begin
         // Writes above the register window are dropped, not aliased.
         s_nxt.wr_pend = hwrite && haddr[31:10] == 22'h00_0000;
         s_nxt.widx = a_idx;
         s_nxt.rdata = 32'h0000_0000;
         // Read data reflects any write retiring on this very edge.
         if (!hwrite && haddr[31:10] == 22'h00_0000) begin
            unique case (a_idx)
               // RQ5 flags read
               `UHI_IDX_FLAGS: begin
                  s_nxt.rdata = {25'h000_0000, rd_flags};
               end
               // RQ6 RQ17 enables read
               `UHI_IDX_ENABLES, `UHI_IDX_CLEARER: begin
                  s_nxt.rdata = {s_nxt.gate, 24'h00_0000, s_nxt.ens};
               end
               `UHI_IDX_TALLY: begin
                  s_nxt.rdata = {14'h0000, s_nxt.tally,
                                 16'h0000};
               end
               `UHI_IDX_MODE: begin
                  s_nxt.rdata = {31'h0000_0000, s_nxt.compat};
               end
               default: begin
               end
            endcase
         end
      end
      // RQ2 gated request
      s_nxt.irq = s_nxt.gate & |(s_nxt.flags & s_nxt.ens);
      // RQ10 halt on fatal
      s_nxt.halt = s_nxt.flags[`UHI_BIT_FATAL];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = s_r.ready;
   assign hrdata = s_r.rdata;
   assign hresp = 1'b0;
   assign irq = s_r.irq;
   assign processing_halt = s_r.halt;

   // The set, clear, keep and quiet checks name one bit of a field; the logic is one vector, so a
   // broken mask or shift shows on the sampled bit as well as on the rest.

   // RQ2 request gating
   a_irq_gating: assert property // RQ2
      (irq == (s_r.gate & |(s_r.flags & s_r.ens)))
      else $error("irq does not match gating");

   // RQ1 flags stay sticky
   a_flag_sticky: assert property // RQ1
      ($fell(s_r.flags[2]) |-> $past(s_r.wr_pend | host_core_reset))
      else $error("flag dropped without a clear");

   // RQ13 frame start flag
   a_frame_sets: assert property // RQ13
      ((frame_start && !host_core_reset) |=> s_r.flags[2])
      else $error("frame start not flagged");

   // RQ7 port change flag
   a_hub_sets: assert property // RQ7
      ((port2_status_change && !host_core_reset) |=> s_r.flags[6])
      else $error("port change not flagged");

   // RQ20 tally advances
   a_tally_step: assert property // RQ20
      ((schedule_overrun && !host_core_reset) |=>
      s_r.tally == $past(s_r.tally) + 2'h1)
      else $error("tally did not advance");

   // RQ15 reserved bits inert
   a_rsvd_zero: assert property // RQ15
      (!s_r.flags[1] && !s_r.ens[1])
      else $error("reserved bit set");

   // RQ10 halt follows fatal
   a_halt_fatal: assert property // RQ10
      (processing_halt == s_r.flags[4])
      else $error("halt not tied to fatal flag");

   // RQ9 compat blocks fatal
   a_compat_zero: assert property // RQ9
      ((s_r.compat && $past(s_r.compat) && !$past(s_r.flags[4]))
      |-> !s_r.flags[4])
      else $error("fatal flag set in compat mode");

   // RQ21 soft reset clears
   a_soft_reset: assert property // RQ21
      (host_core_reset |=> (s_r.ens == 7'h00 && !s_r.gate && !irq))
      else $error("soft reset left enables");

   // RQ21 soft reset flags
   a_reset_flags: assert property // RQ21
      (host_core_reset |=> (s_r.flags == 7'h00 && s_r.tally == 2'h0))
      else $error("soft reset left flags or tally");

   // RQ3 one clears flag
   a_clear_one: assert property // RQ3
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_FLAGS && hwdata[2] &&
      !frame_start) |=> !s_r.flags[2])
      else $error("flag not cleared by one");

   // RQ3 zero keeps flag
   a_clear_zero: assert property // RQ3
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_FLAGS && !hwdata[2] &&
      s_r.flags[2] && !host_core_reset) |=> s_r.flags[2])
      else $error("flag lost on zero write");

   // RQ4 no software set
   a_frame_quiet: assert property // RQ4
      ((!s_r.flags[2] && !frame_start) |=> !s_r.flags[2])
      else $error("frame flag set without event");

   // RQ4 no software set
   a_hub_quiet: assert property // RQ4
      ((!s_r.flags[6] && !hub_status_change && !port1_status_change &&
      !port2_status_change) |=> !s_r.flags[6])
      else $error("hub flag set without event");

   // RQ4 no software set
   a_ovr_quiet: assert property // RQ4
      ((!s_r.flags[0] && !schedule_overrun) |=> !s_r.flags[0])
      else $error("overrun flag set without event");

   // RQ4 no software set
   a_fatal_quiet: assert property // RQ4
      ((!s_r.flags[4] && !system_error) |=> !s_r.flags[4])
      else $error("fatal flag set without event");

   // RQ14 overrun flag set
   a_ovr_sets: assert property // RQ14
      ((schedule_overrun && !host_core_reset) |=> s_r.flags[0])
      else $error("overrun not flagged");

   // RQ20 tally holds otherwise
   a_tally_hold: assert property // RQ20
      ((!schedule_overrun && !host_core_reset) |=> $stable(s_r.tally))
      else $error("tally moved without overrun");

   // RQ12 resume edge flag
   a_resume_sets: assert property // RQ12
      ((resume_signalling && !s_r.res_q && !resume_state &&
      !host_core_reset) |=> s_r.flags[3])
      else $error("resume start not flagged");

   // RQ12 software resume ignored
   a_resume_quiet: assert property // RQ12
      ((!s_r.flags[3] && resume_state) |=> !s_r.flags[3])
      else $error("resume flagged in resume state");

   // RQ8 msb toggle flag
   a_wrap_sets: assert property // RQ8
      ((s_r.msb_seen && frame_number_msb != s_r.msb_q &&
      !host_core_reset) |=> s_r.flags[5])
      else $error("frame msb toggle not flagged");

   // RQ8 steady msb quiet
   a_wrap_quiet: assert property // RQ8
      ((!s_r.flags[5] && frame_number_msb == s_r.msb_q) |=> !s_r.flags[5])
      else $error("wrap flagged without toggle");

   // RQ9 system error flag
   a_fatal_sets: assert property // RQ9
      ((system_error && !s_r.compat && !s_r.wr_pend &&
      !host_core_reset) |=> s_r.flags[4])
      else $error("system error not flagged");

   // RQ7 port one change
   a_port1_sets: assert property // RQ7
      ((port1_status_change && !host_core_reset) |=> s_r.flags[6])
      else $error("port one change not flagged");

   // RQ7 root hub change
   a_root_sets: assert property // RQ7
      ((hub_status_change && !host_core_reset) |=> s_r.flags[6])
      else $error("hub change not flagged");

   // RQ16 one sets enable
   a_en_set: assert property // RQ16
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_ENABLES && hwdata[0] &&
      !host_core_reset) |=> s_r.ens[0])
      else $error("enable not set by one");

   // RQ16 zero keeps enable
   a_en_keep: assert property // RQ16
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_ENABLES && s_r.ens[0] &&
      !host_core_reset) |=> s_r.ens[0])
      else $error("enable lost on enable write");

   // RQ18 gate set by one
   a_gate_set: assert property // RQ18
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_ENABLES && hwdata[31] &&
      !host_core_reset) |=> s_r.gate)
      else $error("gate not set by one");

   // RQ18 gate kept on zero
   a_gate_keep: assert property // RQ18
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_ENABLES && s_r.gate &&
      !host_core_reset) |=> s_r.gate)
      else $error("gate lost on enable write");

   // RQ19 clearer drops gate
   a_clr_gate: assert property // RQ19
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_CLEARER && hwdata[31])
      |=> !s_r.gate)
      else $error("gate not cleared");

   // RQ19 clearer drops enable
   a_clr_en: assert property // RQ19
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_CLEARER && hwdata[2])
      |=> !s_r.ens[2])
      else $error("enable not cleared");

   // RQ19 zero keeps enable
   a_clr_keep: assert property // RQ19
      ((s_r.wr_pend && s_r.widx == `UHI_IDX_CLEARER && !hwdata[2] &&
      s_r.ens[2] && !host_core_reset) |=> s_r.ens[2])
      else $error("enable lost on clearer zero");

   // RQ17 enables read back
   a_en_read: assert property // RQ17
      ((a_take && !hwrite && haddr[31:10] == 22'h00_0000 &&
      a_idx == `UHI_IDX_ENABLES)
      |=> hrdata == {s_r.gate, 24'h00_0000, s_r.ens})
      else $error("enable read data wrong");

   // RQ5 flags read back
   a_flag_read: assert property // RQ5
      ((a_take && !hwrite && haddr[31:10] == 22'h00_0000 &&
      a_idx == `UHI_IDX_FLAGS) |=> hrdata ==
      {25'h000_0000, s_r.flags & ~{2'b00, s_r.compat, 4'h0}})
      else $error("flag read data wrong");

   // RQ5 zero wait bus
   a_ready_high: assert property // RQ5
      (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");

   // RQ21 level request holds
   a_irq_level: assert property // RQ21
      ((s_r.gate && |(s_r.flags & s_r.ens) && !host_core_reset &&
      !s_r.wr_pend) |=> irq)
      else $error("request dropped while gated on");

   // RQ2 closed gate quiet
   a_gate_quiet: assert property // RQ2
      ((!s_r.gate && !(s_r.wr_pend && s_r.widx == `UHI_IDX_ENABLES))
      |=> !irq)
      else $error("request with gate closed");

   // RQ10 halt stays on
   a_halt_hold: assert property // RQ10
      ((s_r.flags[4] && !host_core_reset && !s_r.wr_pend)
      |=> processing_halt)
      else $error("halt released before clear");
endmodule
`default_nettype wire

//--- dv/uhi_evsrc.sv
// Event source model standing for the host core beside the irq block.
`timescale 1ns/100ps
`default_nettype none
module uhi_evsrc (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [8:0] ev,
   output logic [2:0] chg,
   output logic msb,
   output logic err,
   output logic res,
   output logic rstate,
   output logic sof,
   output logic ovr
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {chg, msb, err, res, rstate, sof, ovr} <= 9'h000;
      end else begin
         {ovr, sof, rstate, res, err} <= {ev[8:7], ev[6:4]};
         chg <= ev[2:0];
         // A toggle request flips the counter top bit either way.
         msb <= msb ^ ev[3];
      end
   end
endmodule
`default_nettype wire

//--- dv/usb_host_irq_status_enable_tb.sv
// Self-checking bench of the irq status and enable block.
`timescale 1ns/100ps
`default_nettype none
`include "uhi_regs.svh"
module usb_host_irq_status_enable_tb;
   localparam logic [31:0] AF = `UHI_IDX_FLAGS * 4;
   localparam logic [31:0] AE = `UHI_IDX_ENABLES * 4;
   localparam logic [31:0] AC = `UHI_IDX_CLEARER * 4;
   localparam logic [31:0] AT = `UHI_IDX_TALLY * 4;
   localparam logic [31:0] AM = `UHI_IDX_MODE * 4;
   logic hclk, hresetn, hsel, hwrite, hrdy, hresp, irq, halt, hcr;
   logic msb, err, res, rst, sof, ovr;
   logic [1:0] htrans;
   logic [2:0] chg;
   logic [8:0] ev;
   logic [6:0] f;
   logic [31:0] haddr, hwdata, hrdata, rd, w, en;
   int num_errors, total_checks, nov, k, i;
   int bitof[9] = '{6, 6, 6, 5, 4, 3, 7, 2, 0};
   uhi_evsrc src (.hclk(hclk), .hresetn(hresetn), .ev(ev), .chg(chg),
      .msb(msb), .err(err), .res(res), .rstate(rst), .sof(sof), .ovr(ovr));
   uhi_irq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
      .hresp(hresp), .hub_status_change(chg[0]),
      .port1_status_change(chg[1]), .port2_status_change(chg[2]),
      .frame_number_msb(msb), .system_error(err),
      .resume_signalling(res), .resume_state(rst), .frame_start(sof),
      .schedule_overrun(ovr), .host_core_reset(hcr), .irq(irq),
      .processing_halt(halt));
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic wr,
      input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic fire(input logic [8:0] v);
      @(posedge hclk);
      ev <= v;
      @(posedge hclk);
      ev <= 9'h000;
      repeat (3) @(posedge hclk);
   endtask
   task automatic look();
      bus(AF, 1'b0, 32'h0);
      chk(rd, {25'h0, f});
      bus(AE, 1'b0, 32'h0);
      chk(rd, en);
      bus(AC, 1'b0, 32'h0);
      chk(rd, en);
      chk({31'h0, irq}, {31'h0, (|(f & en[6:0])) & en[31]});
      chk({31'h0, halt}, {31'h0, f[4]});
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hrdy}, 32'h1);
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (8000) @(posedge hclk);
      num_errors++;
      finish_test();
   end
   initial begin
      {hresetn, hsel, hwrite, hcr, htrans} = 6'h10;
      {haddr, hwdata, ev, f, en, nov} = '0;
      k = $urandom(32'h24DD);
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      look();
      bus(AF, 1'b1, 32'hFFFFFFFF);
      for (i = 0; i < 9; i++) begin
         fire(9'h001 << i);
         f |= 7'h7D & (7'h01 << bitof[i]);
         look();
      end
      nov = 1;
      bus(AF, 1'b1, 32'h0);
      bus(AF, 1'b1, 32'h8);
      f[3] = 1'b0;
      fire(9'h060);
      look();
      for (i = 0; i < 40; i++) begin
         w = $urandom;
         k = $urandom % 9;
         case ($urandom % 4)
            0: begin
               bus(AE, 1'b1, w);
               en |= w & 32'h8000007D;
            end
            1: begin
               bus(AC, 1'b1, w);
               en &= ~w;
            end
            2: begin
               w[4] = 1'b0;
               bus(AF, 1'b1, w);
               f &= ~w[6:0];
            end
            default: begin
               fire(9'h001 << k);
               f |= 7'h7D & (7'h01 << bitof[k]);
               nov += (k == 8);
            end
         endcase
         look();
      end
      bus(AT, 1'b0, 32'h0);
      chk(rd, {14'h0, nov[1:0], 16'h0});
      bus(32'h40, 1'b0, 32'h0);
      chk(rd, 32'h0);
      fire(9'h010);
      f[4] = 1'b1;
      @(posedge hclk);
      hcr <= 1'b1;
      @(posedge hclk);
      hcr <= 1'b0;
      f = 7'h00;
      en = 32'h0;
      look();
      bus(AT, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(AF, 1'b1, 32'h10);
      bus(AM, 1'b1, 32'h1);
      fire(9'h010);
      bus(AM, 1'b1, 32'h0);
      look();
      finish_test();
   end
endmodule
`default_nettype wire
